/* pkg/dsl_pkg.sv */
/*
 Constants, field layout and state codes for the port device-sleep control block.
 Assumes a 25 MHz controller clock and an 8-bit register byte address.
*/
package dsl_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] SLEEP_CTRL_OFF = 8'h44;
	// Field layout of the sleep control word
	localparam int MULT_LSB = 25;
	localparam int MULT_W = 4;
	localparam int SLEEP_IDLE_TIMEOUT_LSB = 15;
	localparam int SLEEP_IDLE_TIMEOUT_W = 10;
	localparam int MIN_SLEEP_ASSERT_TIME_LSB = 10;
	localparam int MIN_SLEEP_ASSERT_TIME_W = 5;
	localparam int SLEEP_EXIT_TIMEOUT_LSB = 2;
	localparam int SLEEP_EXIT_TIMEOUT_W = 8;
	localparam int DSP_BIT = 1;
	localparam int AGGRESSIVE_SLEEP_ENABLE_BIT = 0;
	// Reset values of the implementation-specific fields
	localparam logic [3:0] MULT_DEF = 4'h0;
	localparam logic [9:0] SLEEP_IDLE_TIMEOUT_DEF = 10'h064;
	localparam logic [4:0] MIN_SLEEP_ASSERT_TIME_DEF = 5'h0A;
	localparam logic [7:0] SLEEP_EXIT_TIMEOUT_DEF = 8'h14;
	// Codes of the interface control and power state
	localparam logic [3:0] ICC_ACTIVE = 4'h1;
	localparam logic [3:0] ICC_DEVSLEEP = 4'h8;
	localparam logic [3:0] IPM_SLUMBER = 4'h6;
	// Timer widths
	localparam int IDLE_W = 14;
	localparam int HOLD_W = 6;
	localparam int EXIT_W = 8;
	// Millisecond time base
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 40;
	localparam int TICK_CYC = MS_NS / CLK_NS;
	typedef enum logic [2:0] {
		ST_AWAKE = 3'b001,
		ST_SLEEP = 3'b010,
		ST_EXIT = 3'b100
	} dsl_state_e;
endpackage

/* logic/dsl_ms_tick.sv */
/*
 Free-running millisecond prescaler: one-cycle tick every CYCLES clocks.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module dsl_ms_tick import dsl_pkg::*; #(
	parameter int CYCLES = TICK_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	output logic tick_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	localparam logic [CW-1:0] ONE = CW'(1);
	logic [CW-1:0] cnt_reg;
	wire at_last = (cnt_reg == LAST);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_reg <= at_last ? '0 : cnt_reg + ONE;
			tick_o <= at_last;
		end
	end
endmodule

/* logic/dsl_ms_timer.sv */
/*
 Loadable down counter of millisecond ticks; expired while the count is zero.
 Assumes tick_i is a one-cycle pulse from the prescaler.
*/
`timescale 1ns/100ps
module dsl_ms_timer #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic run_i,
	output logic [W-1:0] count_o,
	output logic expired_o
);
	localparam logic [W-1:0] ONE = W'(1);
	assign expired_o = (count_o == '0);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			count_o <= '0;
		else if (load_i)
			count_o <= load_val_i;
		else if (run_i && tick_i && !expired_o)
			count_o <= count_o - ONE;
	end
endmodule

/* logic/dsl_sleep_ctrl.sv */
/*
 Per-port device-sleep control: the sleep control register, idle timer,
 minimum assertion hold and exit timeout, driving the sleep sideband signal.
 Assumes capability, port status and vectors arrive synchronous to clk_i,
 and a register master that never needs wait states.
*/
// The strobed register port is this design's own decision.
//
// Overview of operation
// [R01] Multiplier field read-only, zero-based, bits 28:25
// [R02] Effective timeout is idle field times multiplier+1
// [R03] Ten-bit idle timeout field, bits 24:15
// [R04] Reload idle timer leaving sleep, enable rising
// [R05] Idle field writable only with all three enables
// [R06] Software writes idle field only while stopped
// [R07] Hold sleep asserted at least minimum time
// [R08] Software sets minimum time from device data
// [R09] Minimum and exit fields need support and presence
// [R10] Software writes those fields before sleep request
// [R11] Eight-bit exit timeout field, bits 9:2
// [R12] Presence bit read-only, needs sleep support
// [R13] Presence never with hot-plug or external port
// [R14] Auto sleep after idle timeout when enabled
// [R15] Slumber also required when capability demands
// [R16] Without enable, sleep only on software request
// [R17] Software enables auto sleep only when present
// [R18] Auto sleep enable read-only without capabilities
// [R19] Any port activity restarts the idle countdown
`timescale 1ns/100ps
module dsl_sleep_ctrl import dsl_pkg::*; #(
	parameter logic [3:0] MULT_INIT = MULT_DEF,
	parameter logic [9:0] SLEEP_IDLE_TIMEOUT_INIT = SLEEP_IDLE_TIMEOUT_DEF,
	parameter logic [4:0] MIN_SLEEP_ASSERT_TIME_INIT = MIN_SLEEP_ASSERT_TIME_DEF,
	parameter logic [7:0] SLEEP_EXIT_TIMEOUT_INIT = SLEEP_EXIT_TIMEOUT_DEF,
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic sleep_supported_cap_i,
	input wire logic aggressive_sleep_mgmt_cap_i,
	input wire logic sleep_only_from_slumber_cap_i,
	input wire logic platform_sleep_support_i,
	input wire logic hot_plug_capable_port_i,
	input wire logic external_port_i,
	input wire logic command_engine_start_i,
	input wire logic [3:0] interface_comm_control_i,
	input wire logic interface_comm_control_wr_i,
	input wire logic [31:0] command_issue_vector_i,
	input wire logic [31:0] active_tag_vector_i,
	input wire logic [3:0] interface_power_state_i,
	output logic dev_sleep_o,
	output logic sleep_exit_pending_o
);
	// ==========================================================
	// Effective idle limit
	// ==========================================================
	function automatic logic [IDLE_W-1:0] eff_limit(input logic [SLEEP_IDLE_TIMEOUT_W-1:0] t, input logic [MULT_W-1:0] m);
		logic [SLEEP_IDLE_TIMEOUT_W+MULT_W:0] p;
		p = {5'h00, t} * {11'h000, m} + {5'h00, t};
		return p[IDLE_W-1:0];
	endfunction

	// ==========================================================
	// Register storage and access enables
	// ==========================================================
	logic [SLEEP_IDLE_TIMEOUT_W-1:0] sleep_idle_timeout_reg;
	logic [MIN_SLEEP_ASSERT_TIME_W-1:0] min_sleep_assert_time_reg;
	logic [SLEEP_EXIT_TIMEOUT_W-1:0] sleep_exit_timeout_reg;
	logic aggressive_sleep_enable_reg;
	logic aggressive_sleep_enable_prev_reg;
	dsl_state_e state_reg;
	dsl_state_e state_next;

	wire [MULT_W-1:0] mult_val = MULT_INIT; // R01
	wire dsp = platform_sleep_support_i & sleep_supported_cap_i // R12
		& ~hot_plug_capable_port_i & ~external_port_i; // R13
	wire auto_en = sleep_supported_cap_i & aggressive_sleep_mgmt_cap_i & dsp;
	wire timing_en = sleep_supported_cap_i & dsp;
	wire reg_hit = (reg_addr_i == SLEEP_CTRL_OFF);
	wire wr_hit = reg_wr_i & reg_hit;
	wire rd_hit = reg_rd_i & reg_hit;

	wire [SLEEP_IDLE_TIMEOUT_W-1:0] sleep_idle_timeout_eff = auto_en ? sleep_idle_timeout_reg : '0; // R05
	wire [MIN_SLEEP_ASSERT_TIME_W-1:0] min_sleep_assert_time_eff = timing_en ? min_sleep_assert_time_reg : '0; // R09
	wire [SLEEP_EXIT_TIMEOUT_W-1:0] sleep_exit_timeout_eff = timing_en ? sleep_exit_timeout_reg : '0; // R09
	wire aggressive_sleep_enable_eff = auto_en & aggressive_sleep_enable_reg; // R18

	wire [31:0] rd_word = {3'h0, mult_val, sleep_idle_timeout_eff, min_sleep_assert_time_eff, sleep_exit_timeout_eff, dsp, aggressive_sleep_enable_eff};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sleep_idle_timeout_reg <= SLEEP_IDLE_TIMEOUT_INIT;
			min_sleep_assert_time_reg <= MIN_SLEEP_ASSERT_TIME_INIT;
			sleep_exit_timeout_reg <= SLEEP_EXIT_TIMEOUT_INIT;
		end else begin
			if (wr_hit && auto_en)
				sleep_idle_timeout_reg <= reg_wdata_i[SLEEP_IDLE_TIMEOUT_LSB +: SLEEP_IDLE_TIMEOUT_W]; // R03 R05
			if (wr_hit && timing_en) begin
				min_sleep_assert_time_reg <= reg_wdata_i[MIN_SLEEP_ASSERT_TIME_LSB +: MIN_SLEEP_ASSERT_TIME_W]; // R07 R09
				sleep_exit_timeout_reg <= reg_wdata_i[SLEEP_EXIT_TIMEOUT_LSB +: SLEEP_EXIT_TIMEOUT_W]; // R11 R09
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !auto_en)
			aggressive_sleep_enable_reg <= 1'b0; // R18
		else if (wr_hit)
			aggressive_sleep_enable_reg <= reg_wdata_i[AGGRESSIVE_SLEEP_ENABLE_BIT]; // R17
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= '0;
		else
			reg_rdata_o <= rd_hit ? rd_word : '0;
	end

	// ==========================================================
	// Port activity and sleep conditions
	// ==========================================================
	wire port_busy = (command_issue_vector_i != '0) | (active_tag_vector_i != '0);
	wire slumber_ok = ~sleep_only_from_slumber_cap_i | (interface_power_state_i == IPM_SLUMBER); // R15
	wire sw_sleep = interface_comm_control_wr_i & (interface_comm_control_i == ICC_DEVSLEEP);
	wire sw_wake = interface_comm_control_wr_i & (interface_comm_control_i == ICC_ACTIVE);
	wire aggressive_sleep_enable_rise = aggressive_sleep_enable_eff & ~aggressive_sleep_enable_prev_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			aggressive_sleep_enable_prev_reg <= 1'b0;
		else
			aggressive_sleep_enable_prev_reg <= aggressive_sleep_enable_eff;
	end

	// ==========================================================
	// Timers
	// ==========================================================
	logic tick;
	logic [IDLE_W-1:0] idle_cnt;
	logic idle_done;
	logic [HOLD_W-1:0] hold_cnt;
	logic hold_done;
	logic [EXIT_W-1:0] exit_cnt;
	logic exit_done;

	wire in_awake = (state_reg == ST_AWAKE);
	wire in_sleep = (state_reg == ST_SLEEP);
	wire in_exit = (state_reg == ST_EXIT);
	wire [IDLE_W-1:0] idle_limit = eff_limit(sleep_idle_timeout_eff, mult_val); // R02
	wire leave_sleep = in_sleep & (state_next == ST_EXIT);
	wire enter_sleep = in_awake & (state_next == ST_SLEEP);
	wire idle_load = port_busy | leave_sleep | aggressive_sleep_enable_rise; // R04 R19
	wire idle_run = in_awake & aggressive_sleep_enable_eff & ~port_busy;
	wire auto_go = aggressive_sleep_enable_eff & ~port_busy & slumber_ok & idle_done & ~aggressive_sleep_enable_rise; // R14 R15
	wire [HOLD_W-1:0] hold_load_val = {1'b0, min_sleep_assert_time_eff} + 6'h01;
	wire wake_req = port_busy | sw_wake;

	dsl_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	dsl_ms_timer #(.W(IDLE_W)) u_idle (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick),
		.load_i(idle_load),
		.load_val_i(idle_limit),
		.run_i(idle_run),
		.count_o(idle_cnt),
		.expired_o(idle_done)
	);

	// One extra tick makes the free-running prescaler give at least the full time
	dsl_ms_timer #(.W(HOLD_W)) u_hold (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick),
		.load_i(enter_sleep),
		.load_val_i(hold_load_val),
		.run_i(in_sleep),
		.count_o(hold_cnt),
		.expired_o(hold_done)
	);

	dsl_ms_timer #(.W(EXIT_W)) u_exit (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick),
		.load_i(leave_sleep),
		.load_val_i(sleep_exit_timeout_eff),
		.run_i(in_exit),
		.count_o(exit_cnt),
		.expired_o(exit_done)
	);

	// ==========================================================
	// Sleep state machine
	// ==========================================================
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_AWAKE: begin
				if (sw_sleep || auto_go) // R14 R16
					state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wake_req && hold_done) // R07
					state_next = ST_EXIT;
			end
			ST_EXIT: begin
				if (exit_done)
					state_next = ST_AWAKE;
			end
			default: state_next = ST_AWAKE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			state_reg <= ST_AWAKE;
		else
			state_reg <= state_next;
	end

	assign dev_sleep_o = in_sleep;
	assign sleep_exit_pending_o = in_exit;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic [HOLD_W-1:0] held_ms_reg;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !in_sleep)
			held_ms_reg <= '0;
		else if (tick && held_ms_reg != '1)
			held_ms_reg <= held_ms_reg + 6'h01;
	end

	sequence read_cycle_s;
		rd_hit ##1 1'b1;
	endsequence

	sequence enabled_write_s;
		wr_hit && auto_en && !$past(sys_rst_i);
	endsequence

	mult_readonly_a: assert property ( // R01
		read_cycle_s |-> reg_rdata_o[MULT_LSB +: MULT_W] == MULT_INIT)
		else $error("multiplier field not the fixed value");

	sleep_idle_timeout_locked_a: assert property ( // R05
		rd_hit && !auto_en |=> reg_rdata_o[SLEEP_IDLE_TIMEOUT_LSB +: SLEEP_IDLE_TIMEOUT_W] == '0 && reg_rdata_o[AGGRESSIVE_SLEEP_ENABLE_BIT] == 1'b0)
		else $error("idle timeout visible while locked");

	sleep_idle_timeout_store_a: assert property ( // R03
		enabled_write_s ##1 !wr_hit ##1 (auto_en && rd_hit)
		|=> reg_rdata_o[SLEEP_IDLE_TIMEOUT_LSB +: SLEEP_IDLE_TIMEOUT_W] == $past(reg_wdata_i[SLEEP_IDLE_TIMEOUT_LSB +: SLEEP_IDLE_TIMEOUT_W], 3))
		else $error("idle timeout read back wrong");

	timing_locked_a: assert property ( // R09
		rd_hit && !timing_en |=> reg_rdata_o[MIN_SLEEP_ASSERT_TIME_LSB +: MIN_SLEEP_ASSERT_TIME_W] == '0 && reg_rdata_o[SLEEP_EXIT_TIMEOUT_LSB +: SLEEP_EXIT_TIMEOUT_W] == '0)
		else $error("timing fields visible while locked");

	present_cap_a: assert property ( // R12
		rd_hit && !sleep_supported_cap_i |=> reg_rdata_o[DSP_BIT] == 1'b0)
		else $error("presence shown without sleep support");

	present_excl_a: assert property ( // R13
		rd_hit && (hot_plug_capable_port_i || external_port_i) |=> !reg_rdata_o[DSP_BIT])
		else $error("presence shown with hot-plug or external port");

	idle_reload_a: assert property ( // R04
		(aggressive_sleep_enable_rise || leave_sleep) && !port_busy |=> idle_cnt == $past(idle_limit))
		else $error("idle timer not reloaded");

	busy_restart_a: assert property ( // R19
		port_busy |=> idle_cnt == $past(idle_limit) && !dev_sleep_o || $past(in_sleep))
		else $error("activity did not restart idle countdown");

	auto_entry_a: assert property ( // R14
		in_awake && aggressive_sleep_enable_eff && !port_busy && slumber_ok && idle_done && !aggressive_sleep_enable_rise |=> dev_sleep_o)
		else $error("auto sleep not taken after idle timeout");

	slumber_need_a: assert property ( // R15
		$rose(dev_sleep_o) && !$past(sw_sleep) && sleep_only_from_slumber_cap_i
		|-> $past(interface_power_state_i) == IPM_SLUMBER)
		else $error("auto sleep outside slumber");

	no_auto_a: assert property ( // R16
		$rose(dev_sleep_o) |-> $past(sw_sleep) || $past(aggressive_sleep_enable_eff))
		else $error("sleep entered with no request");

	min_hold_a: assert property ( // R07
		$fell(dev_sleep_o) |-> $past(held_ms_reg) > $past(min_sleep_assert_time_eff))
		else $error("sleep released before minimum time");
endmodule

/* tb/dsl_dev_model.sv */
/*
 Behavioural model of the attached storage device on the sleep sideband.
 Assumes the sideband is a clean active-high level synchronous to clk_i.
*/
`timescale 1ns/100ps
module dsl_dev_model (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic dev_sleep_i,
	output logic [15:0] hold_cyc_o,
	output logic asleep_o
);
	logic [15:0] run_reg;
	// ==========================================
	// Measure how long each sleep assertion lasts
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			run_reg <= 16'h0000;
			hold_cyc_o <= 16'h0000;
		end else if (dev_sleep_i) begin
			run_reg <= run_reg + 16'h0001;
		end else begin
			if (run_reg != 16'h0000) begin
				hold_cyc_o <= run_reg;
			end
			run_reg <= 16'h0000;
		end
	end
	assign asleep_o = dev_sleep_i;
endmodule

/* tb/dsl_sleep_ctrl_tb.sv */
/*
 Self-checking bench for the port device-sleep control block.
 Assumes a 4-cycle millisecond tick so that all timers finish quickly.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %0h got %0h", n, e, a); end end
module dsl_sleep_ctrl_tb;
	import dsl_pkg::*;
	localparam int TK = 4;
	logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, sds = 1, sadm = 1, deso = 0, plat = 1;
	logic hpc = 0, ext = 0, icc_wr = 0, dev_sleep_o, pend;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, ci = 32'h0, sact = 32'h0;
	logic [3:0] icc = 4'h0, ipm = 4'h0;
	logic [15:0] hold;
	int miscompares = 0, tests_run = 0, n;
	always #20 clk_i = ~clk_i;
	dsl_sleep_ctrl #(.MULT_INIT(4'h1), .SLEEP_IDLE_TIMEOUT_INIT(10'h003), .MIN_SLEEP_ASSERT_TIME_INIT(5'h02), .SLEEP_EXIT_TIMEOUT_INIT(8'h03),
		.TICK_CYCLES(TK)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.sleep_supported_cap_i(sds), .aggressive_sleep_mgmt_cap_i(sadm), .sleep_only_from_slumber_cap_i(deso),
		.platform_sleep_support_i(plat), .hot_plug_capable_port_i(hpc), .external_port_i(ext),
		.command_engine_start_i(1'b0), .interface_comm_control_i(icc), .interface_comm_control_wr_i(icc_wr),
		.command_issue_vector_i(ci), .active_tag_vector_i(sact), .interface_power_state_i(ipm),
		.dev_sleep_o(dev_sleep_o), .sleep_exit_pending_o(pend));
	dsl_dev_model u_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .dev_sleep_i(dev_sleep_o), .hold_cyc_o(hold),
		.asleep_o());
	function automatic logic [31:0] wd(input logic [9:0] d, input logic [4:0] m, input logic [7:0] e,
		input logic en);
		return {7'h00, d, m, e, 1'b0, en};
	endfunction
	// ==========================================
	// Register bus, sleep-level wait and control request tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
		@(posedge clk_i);
	endtask
	task automatic wait_lvl(input logic lvl, input int lim);
		n = 0;
		while (dev_sleep_o !== lvl && n < lim) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask
	task automatic icc_req(input logic [3:0] c);
		@(posedge clk_i);
		icc <= c;
		icc_wr <= 1'b1;
		@(posedge clk_i);
		icc_wr <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		logic [31:0] d;
		rd(SLEEP_CTRL_OFF, d);
		`CHK("reset word", {3'h0, 4'h1, 10'h003, 5'h02, 8'h03, 2'b10}, d)
		rd(8'h40, d);
		`CHK("unmapped", 32'h0, d)
		wr(SLEEP_CTRL_OFF, 32'hFFFF_FFFE);
		rd(SLEEP_CTRL_OFF, d);
		`CHK("all ones", 32'h03FF_FFFE, d)
		wr(SLEEP_CTRL_OFF, wd(10'h003, 5'h02, 8'h03, 1'b0));
	endtask
	task automatic t_auto;
		wr(SLEEP_CTRL_OFF, wd(10'h003, 5'h02, 8'h03, 1'b1));
		repeat (14) @(posedge clk_i);
		ci <= 32'h0000_0100;
		@(posedge clk_i);
		ci <= 32'h0;
		wait_lvl(1'b1, 60);
		`CHK("idle restart min", 1'b1, n >= 5 * TK)
		`CHK("idle timeout max", 1'b1, n <= 7 * TK + 3)
		`CHK("auto sleep", 1'b1, dev_sleep_o)
		@(posedge clk_i);
		sact <= 32'h1;
		wait_lvl(1'b0, 40);
		@(posedge clk_i);
		#1 `CHK("min hold", 1'b1, hold >= 16'(2 * TK))
		`CHK("exit pending", 1'b1, pend)
		repeat (20) @(posedge clk_i);
		#1 `CHK("exit done", 1'b0, pend)
		@(posedge clk_i);
		sact <= 32'h0;
		wait_lvl(1'b1, 60);
		`CHK("reload after exit", 1'b1, n >= 5 * TK)
		wr(SLEEP_CTRL_OFF, wd(10'h003, 5'h02, 8'h03, 1'b0));
		ci <= 32'h1;
		wait_lvl(1'b0, 40);
		@(posedge clk_i);
		ci <= 32'h0;
		repeat (20) @(posedge clk_i);
	endtask
	task automatic t_slumber;
		deso <= 1'b1;
		ipm <= 4'h2;
		wr(SLEEP_CTRL_OFF, wd(10'h003, 5'h02, 8'h03, 1'b1));
		wait_lvl(1'b1, 60);
		`CHK("no sleep outside slumber", 1'b0, dev_sleep_o)
		@(posedge clk_i);
		ipm <= IPM_SLUMBER;
		wait_lvl(1'b1, 30);
		`CHK("sleep in slumber", 1'b1, dev_sleep_o)
		wr(SLEEP_CTRL_OFF, wd(10'h003, 5'h02, 8'h03, 1'b0));
		ci <= 32'h1;
		wait_lvl(1'b0, 40);
		@(posedge clk_i);
		ci <= 32'h0;
		deso <= 1'b0;
		repeat (20) @(posedge clk_i);
	endtask
	task automatic t_soft;
		wait_lvl(1'b1, 60);
		`CHK("no auto when disabled", 1'b0, dev_sleep_o)
		icc_req(ICC_DEVSLEEP);
		#1 `CHK("software sleep", 1'b1, dev_sleep_o)
		// A wake pulse is only honoured once the minimum hold has run out
		repeat (4 * TK) @(posedge clk_i);
		icc_req(ICC_ACTIVE);
		wait_lvl(1'b0, 40);
		`CHK("software wake", 1'b0, dev_sleep_o)
		repeat (20) @(posedge clk_i);
	endtask
	task automatic t_gate;
		logic [31:0] d;
		sadm <= 1'b0;
		wr(SLEEP_CTRL_OFF, wd(10'h005, 5'h04, 8'h06, 1'b1));
		rd(SLEEP_CTRL_OFF, d);
		`CHK("no mgmt cap", {3'h0, 4'h1, 10'h000, 5'h04, 8'h06, 2'b10}, d)
		sadm <= 1'b1;
		rd(SLEEP_CTRL_OFF, d);
		`CHK("idle kept", {3'h0, 4'h1, 10'h003, 5'h04, 8'h06, 2'b10}, d)
		hpc <= 1'b1;
		rd(SLEEP_CTRL_OFF, d);
		`CHK("hot plug", 32'h0200_0000, d)
		hpc <= 1'b0;
		ext <= 1'b1;
		rd(SLEEP_CTRL_OFF, d);
		`CHK("external", 32'h0200_0000, d)
		ext <= 1'b0;
		sds <= 1'b0;
		wr(SLEEP_CTRL_OFF, 32'hFFFF_FFFF);
		rd(SLEEP_CTRL_OFF, d);
		`CHK("no support", 32'h0200_0000, d)
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_auto;
		t_slumber;
		t_soft;
		t_gate;
		complete_run;
	end
endmodule
